// ---- hw/adcsp_defs.svh ----
// adcsp_defs.svh: timing counts, bit counts and reset values of the converter serial port
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and status-test timing
// ----------------------------------------------------------------------------
`define ADCSP_CLK_MHZ             125
`define ADCSP_STATUS_TEST_DELAY_US 12
`define ADCSP_STATUS_TEST_CYC     ((`ADCSP_STATUS_TEST_DELAY_US) * (`ADCSP_CLK_MHZ))

// ----------------------------------------------------------------------------
// transfer framing
// ----------------------------------------------------------------------------
`define ADCSP_XFER_BITS           24
`define ADCSP_RES_BITS            23
`define ADCSP_CFG_BITS            8
`define ADCSP_SCK_HALF_CYC        10
`define ADCSP_CONV_CYC            1000000
`define ADCSP_FIFO_DEPTH          8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ADCSP_RST_SCK             1'b1
`define ADCSP_RST_SDO             1'b1
`define ADCSP_RST_PULLUP          1'b1

`endif

// ---- hw/adcsp_pkg.sv ----
// adcsp_pkg: types shared by the converter serial port
package adcsp_pkg;

  // ----------------------------------------------------------------------------
  // port sequencer states, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_CONV  = 3'b001,  // converting, busy flag high
    ST_SLEEP = 3'b010,  // result held, low power or status test
    ST_XFER  = 3'b100   // shifting the result out
  } adcsp_state_t;

endpackage : adcsp_pkg

// ---- hw/adcsp_port.sv ----
// adcsp_port: result fifo and internal-clock serial output port of the converter
// Behaviour
// - clock pin high at select fall picks internal
// - weak pull-up on clock pin at select fall
// - data output high impedance while select high
// - select low: clock low, busy flag out
// - finished status test leaves sleep meanwhile
// - status test delay then clock and data
// - sample input rising, shift output falling, 24
// - after 24th: data high, clock high, convert
// - select rise mid-transfer aborts and converts
// - partial configuration discarded, old one kept
// - select rise while clock low loses internal
// - pull-up off while clock pin is low, save at select rise after asleep test
// - select high after asleep test restores pull-up
// - pull-up on in reset, mode from pin
// - continuous: both high converting, low done
// - continuous: half clock asleep then transfer
// - continuous: after 24th data high, clock high
// - sleep on completion regardless of select
`include "adcsp_defs.svh"

// ----------------------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------------------
module adcsp_fifo #(
  parameter int WIDTH = `ADCSP_RES_BITS,
  parameter int DEPTH = `ADCSP_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];      // storage words
  logic [AW-1:0]    wrPtr_r;          // next slot to fill
  logic [AW-1:0]    rdPtr_r;          // oldest word
  logic [AW:0]      count_r;          // words held
  logic             inReady_r;        // registered not-full
  logic             push;
  logic             pop;

  assign push     = inValid && inReady_r;
  assign pop      = outReady && (count_r != '0);
  assign inReady  = inReady_r;
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  // pointer wrap for depths that are not a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // storage write, no reset needed on data
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers and fill level; ready drops in the same cycle that the fill level reaches full
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wrPtr_r   <= '0;
      rdPtr_r   <= '0;
      count_r   <= '0;
      inReady_r <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wrPtr_r <= bump(wrPtr_r);
      end
      if (pop)
      begin
        rdPtr_r <= bump(rdPtr_r);
      end
      if (push && !pop)
      begin
        count_r   <= count_r + 1'b1;
        inReady_r <= (count_r + 1'b1) < (AW+1)'(DEPTH);
      end
      else if (pop && !push)
      begin
        count_r   <= count_r - 1'b1;
        inReady_r <= 1'b1;
      end
    end
  end
endmodule : adcsp_fifo

// ----------------------------------------------------------------------------
// serial port top
// ----------------------------------------------------------------------------
module adcsp_port #(
  parameter int RES_BITS   = `ADCSP_RES_BITS,     // result bits after the busy flag
  parameter int CFG_BITS   = `ADCSP_CFG_BITS,     // input bits, last is the speed select
  parameter int SCK_HALF   = `ADCSP_SCK_HALF_CYC, // half internal clock period, cycles
  parameter int CONV_CYC   = `ADCSP_CONV_CYC,     // conversion length, cycles
  parameter int FIFO_DEPTH = `ADCSP_FIFO_DEPTH
) (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                csN,          // chip select pin, async
  input  wire logic                sdi,          // data input pin, async
  input  wire logic                sckIn,        // clock pin level, async
  output logic                     sckOut,       // clock pin drive value
  output logic                     sckOe,        // clock pin drive enable
  output logic                     sckPullUpEn,  // weak pull-up enable
  output logic                     sdoOut,       // data output value
  output logic                     sdoOe,        // data output enable
  input  wire logic [RES_BITS-1:0] resData,      // result word from the core
  input  wire logic                resValid,
  output logic                     resReady,
  output logic                     convStart,    // pulse: new conversion begins
  output logic                     sleepMode,    // low power sleep
  output logic                     intSckMode,   // internal clock mode selected
  output logic [CFG_BITS-1:0]      cfgWord,      // last fully loaded configuration
  output logic                     cfgLoad       // pulse: cfgWord updated
);
  localparam logic [15:0] TEST_CYC = 16'(`ADCSP_STATUS_TEST_CYC);
  localparam logic [15:0] HALF_CYC = 16'(SCK_HALF);

  // synchronisers, first stage read by second stage only
  logic csS1_r, csS2_r, csPrev_r;
  logic sckS1_r, sckS2_r;
  logic sdiS1_r, sdiS2_r;

  adcsp_pkg::adcsp_state_t state_r;  // sequencer state
  logic [31:0]         convCnt_r;    // conversion timer
  logic [15:0]         timer_r;      // sleep / status test timer
  logic [15:0]         halfCnt_r;    // internal clock half period
  logic [5:0]          bitCnt_r;     // rising edges seen
  logic [RES_BITS-1:0] shift_r;      // result shift register
  logic [CFG_BITS-1:0] cfgShift_r;   // partial configuration
  logic [7:0]          cfgCnt_r;     // configuration bits loaded
  logic [CFG_BITS-1:0] cfgWord_r;
  logic                cfgLoad_r;
  logic [1:0]          por_r;        // cycles since reset release
  logic                intMode_r;    // internal clock mode
  logic                contMode_r;   // continuous three-wire mode
  logic                testAsleep_r; // status test found a result
  logic                pullUp_r;
  logic                sckOut_r, sckOe_r, sdoOut_r, sdoOe_r;
  logic                convStart_r, sleep_r;

  logic csLow, csFall, csRise;
  logic tick, sckRise, sckFall, lastRise, abortX, convDone, pullSet;
  logic [RES_BITS-1:0] fifoData;
  logic fifoValid;

  assign csLow    = !csS2_r;
  assign csFall   = csPrev_r && !csS2_r;
  assign csRise   = !csPrev_r && csS2_r;
  assign tick     = (state_r == adcsp_pkg::ST_XFER) && (halfCnt_r == HALF_CYC - 16'h0001);
  assign sckRise  = tick && !sckOut_r;
  assign sckFall  = tick && sckOut_r;
  assign lastRise = sckRise && (bitCnt_r == 6'(`ADCSP_XFER_BITS - 1));
  assign abortX   = (state_r == adcsp_pkg::ST_XFER) && csRise && !contMode_r;
  // completion waits for a result word, so a slow core stalls the converter
  assign convDone = (state_r == adcsp_pkg::ST_CONV) && (convCnt_r >= 32'(CONV_CYC - 1)) && fifoValid;
  assign pullSet  = csRise && testAsleep_r;

  assign sckOut      = sckOut_r;
  assign sckOe       = sckOe_r;
  assign sckPullUpEn = pullUp_r;
  assign sdoOut      = sdoOut_r;
  assign sdoOe       = sdoOe_r;
  assign convStart   = convStart_r;
  assign sleepMode   = sleep_r;
  assign intSckMode  = intMode_r;
  assign cfgWord     = cfgWord_r;
  assign cfgLoad     = cfgLoad_r;

  // result words wait here until a conversion completes
  adcsp_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) resFifo (
    .mclk     (mclk),
    .srst     (srst),
    .inData   (resData),
    .inValid  (resValid),
    .inReady  (resReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (convDone)
  );

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  // idle levels in reset so no false select edge at release
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      csS1_r <= 1'b1; csS2_r <= 1'b1; csPrev_r <= 1'b1;
      sckS1_r <= 1'b1; sckS2_r <= 1'b1;
      sdiS1_r <= 1'b0; sdiS2_r <= 1'b0;
    end
    else
    begin
      csS1_r <= csN;   csS2_r <= csS1_r;  csPrev_r <= csS2_r;
      sckS1_r <= sckIn; sckS2_r <= sckS1_r;
      sdiS1_r <= sdi;  sdiS2_r <= sdiS1_r;
    end
  end

  // ----------------------------------------------------------------------------
  // clock mode selection
  // ----------------------------------------------------------------------------
  // pin level is caught two cycles after release, once the synchroniser is valid
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      por_r      <= 2'h0;
      intMode_r  <= 1'b0;
      contMode_r <= 1'b0;
    end
    else
    begin
      if (por_r != 2'h3)
      begin
        por_r <= por_r + 2'h1;
      end
      if (por_r == 2'h2)
      begin
        intMode_r  <= sckS2_r;
        contMode_r <= sckS2_r;
      end
      else if (csFall)
      begin
        // a pin left low by an earlier abort lands us in external mode
        intMode_r  <= sckS2_r;
        contMode_r <= 1'b0;
      end
      else if (csRise)
      begin
        contMode_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // conversion and transfer sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_r      <= adcsp_pkg::ST_CONV;
      convCnt_r    <= '0;
      timer_r      <= '0;
      halfCnt_r    <= '0;
      bitCnt_r     <= '0;
      shift_r      <= '0;
      convStart_r  <= 1'b0;
      sleep_r      <= 1'b0;
      testAsleep_r <= 1'b0;
    end
    else
    begin
      convStart_r <= 1'b0;
      case (state_r)
        adcsp_pkg::ST_CONV:
        begin
          convCnt_r <= convCnt_r + 32'h1;
          if (convDone)
          begin
            state_r <= adcsp_pkg::ST_SLEEP;
            shift_r <= fifoData;
            sleep_r <= 1'b1;
            timer_r <= '0;
          end
        end
        adcsp_pkg::ST_SLEEP:
        begin
          if (intMode_r && csLow)
          begin
            // delay runs from select fall or from entering sleep with select low
            sleep_r      <= contMode_r;
            testAsleep_r <= !contMode_r;
            timer_r      <= timer_r + 16'h0001;
            if (timer_r == (contMode_r ? HALF_CYC : TEST_CYC) - 16'h0001)
            begin
              state_r      <= adcsp_pkg::ST_XFER;
              halfCnt_r    <= '0;
              bitCnt_r     <= '0;
              testAsleep_r <= 1'b0;
              sleep_r      <= 1'b0;
            end
          end
          else
          begin
            // select back high before the first edge keeps the result
            timer_r      <= '0;
            sleep_r      <= 1'b1;
            testAsleep_r <= 1'b0;
          end
        end
        adcsp_pkg::ST_XFER:
        begin
          halfCnt_r <= tick ? 16'h0000 : halfCnt_r + 16'h0001;
          if (sckFall)
          begin
            shift_r <= {shift_r[RES_BITS-2:0], 1'b1};
          end
          if (sckRise)
          begin
            bitCnt_r <= bitCnt_r + 6'h01;
          end
          if (lastRise || abortX)
          begin
            state_r     <= adcsp_pkg::ST_CONV;
            convCnt_r   <= '0;
            convStart_r <= 1'b1;
          end
        end
        default:
        begin
          state_r <= adcsp_pkg::ST_CONV;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // clock and data pins
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sckOut_r <= `ADCSP_RST_SCK;
      sckOe_r  <= 1'b0;
      sdoOut_r <= `ADCSP_RST_SDO;
      sdoOe_r  <= 1'b0;
    end
    else
    begin
      sdoOe_r <= csLow;
      // the mode picked at this select fall gates the drive too, so an outside low is never fought
      sckOe_r <= (csFall ? sckS2_r : intMode_r) && csLow;
      if (lastRise || abortX)
      begin
        // data holds across the last rise so the host still takes the final bit
        sckOut_r <= 1'b1;
      end
      else if (sckRise)
      begin
        sckOut_r <= 1'b1;
      end
      else if (sckFall)
      begin
        sckOut_r <= 1'b0;
        sdoOut_r <= shift_r[RES_BITS-1];
      end
      else if (convDone)
      begin
        sdoOut_r <= 1'b0;
        if (contMode_r)
        begin
          sckOut_r <= 1'b0;
        end
      end
      else if (convStart_r)
      begin
        // busy shown one cycle after the transfer ends
        sdoOut_r <= 1'b1;
      end
      else if (por_r == 2'h2)
      begin
        // a select held low shows a fall here too; the reset pick of the mode wins
        sckOut_r <= 1'b1;
      end
      else if (csFall)
      begin
        sckOut_r <= 1'b0;
        sdoOut_r <= (state_r != adcsp_pkg::ST_SLEEP);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // configuration input
  // ----------------------------------------------------------------------------
  // the word is taken only once its last bit is in; an abort simply drops it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfgShift_r <= '0;
      cfgCnt_r   <= '0;
      cfgWord_r  <= '0;
      cfgLoad_r  <= 1'b0;
    end
    else
    begin
      cfgLoad_r <= 1'b0;
      if (state_r != adcsp_pkg::ST_XFER)
      begin
        cfgCnt_r <= '0;
      end
      else if (sckRise && !abortX && (cfgCnt_r < 8'(CFG_BITS)))
      begin
        cfgShift_r <= {cfgShift_r[CFG_BITS-2:0], sdiS2_r};
        cfgCnt_r   <= cfgCnt_r + 8'h01;
        if (cfgCnt_r == 8'(CFG_BITS - 1))
        begin
          cfgWord_r <= {cfgShift_r[CFG_BITS-2:0], sdiS2_r};
          cfgLoad_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // clock pin pull-up
  // ----------------------------------------------------------------------------
  // a low pin, ours or anyone's, turns the pull-up off; a heavy load may still hold it low
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pullUp_r <= `ADCSP_RST_PULLUP;
    end
    else if (pullSet)
    begin
      pullUp_r <= 1'b1;
    end
    else if (!sckS2_r)
    begin
      pullUp_r <= 1'b0;
    end
    else
    begin
      pullUp_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  modeSel_a: assert property (@(posedge mclk) disable iff (srst)
    csFall && (por_r == 2'h3) |=> intMode_r == $past(sckS2_r))
    else $error("clock mode not taken from pin at select fall");

  pullOff_a: assert property (@(posedge mclk) disable iff (srst)
    !sckS2_r && !pullSet |=> !pullUp_r)
    else $error("pull-up stays on with clock pin low");

  sdoHiZ_a: assert property (@(posedge mclk) disable iff (srst)
    csS2_r ##1 csS2_r |-> !sdoOe_r)
    else $error("data output driven while select high");

  testDelay_a: assert property (@(posedge mclk) disable iff (srst)
    (state_r == adcsp_pkg::ST_XFER) && ($past(state_r) == adcsp_pkg::ST_SLEEP) && !contMode_r
      |-> $past(timer_r) == TEST_CYC - 16'h0001)
    else $error("status test delay wrong");

  xferEnd_a: assert property (@(posedge mclk) disable iff (srst)
    lastRise |=> (state_r == adcsp_pkg::ST_CONV) && sckOut_r && convStart_r ##1 sdoOut_r)
    else $error("transfer end not followed by conversion");

  abortConv_a: assert property (@(posedge mclk) disable iff (srst)
    abortX |=> (state_r == adcsp_pkg::ST_CONV) && convStart_r && (convCnt_r == 32'h0))
    else $error("abort did not start a conversion");

  cfgKeep_a: assert property (@(posedge mclk) disable iff (srst)
    abortX && (cfgCnt_r < 8'(CFG_BITS)) |=> $stable(cfgWord_r) && !cfgLoad_r)
    else $error("partial configuration taken");

  contLevel_a: assert property (@(posedge mclk) disable iff (srst)
    contMode_r && convDone |=> !sdoOut_r && !sckOut_r ##1 (sdoOut_r == 1'b0))
    else $error("continuous completion not signalled low");

  autoSleep_a: assert property (@(posedge mclk) disable iff (srst)
    convDone |=> (state_r == adcsp_pkg::ST_SLEEP) && sleep_r)
    else $error("no sleep after completion");
endmodule : adcsp_port

// ---- tb/adcsp_host.sv ----
// adcsp_host: serial master model that stands on the far side of the converter port
module adcsp_host (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        csN,          // select level as the bench drives it
  input  wire logic        sckOut,
  input  wire logic        sckOe,
  input  wire logic        sckPullUpEn,
  input  wire logic        sdoOut,
  input  wire logic        sdoOe,
  input  wire logic        extLow,       // outside driver pulls the clock pin low
  input  wire logic [7:0]  cfgTx,        // configuration word to send, msb first
  output logic             sckIn,        // resolved clock pin
  output logic             sdi,
  output logic [23:0]      rxWord,       // last 24 bits captured
  output logic [5:0]       rxCnt         // rising edges seen in this frame
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------------------
  logic sckHeld_r;                       // pin keeps its level when nobody acts on it
  logic sckPrev_r;
  logic csPrev_r;
  logic sdoLast_r;
  logic sdoPin;

  // a released pin without pull-up stays where it was, so a low sticks
  always_comb sckIn = sckOe ? sckOut : (extLow ? 1'h0 : (sckPullUpEn ? 1'h1 : sckHeld_r));
  // released data line shows no stale value
  assign sdoPin = sdoOe ? sdoOut : ~sdoLast_r;

  // edge history of the pins
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sckHeld_r <= 1'h1;
      sckPrev_r <= 1'h1;
      csPrev_r  <= 1'h1;
      sdoLast_r <= 1'h1;
    end
    else
    begin
      sckHeld_r <= sckIn;
      sckPrev_r <= sckIn;
      csPrev_r  <= csN;
      sdoLast_r <= sdoPin;
    end
  end

  // ----------------------------------------------------------------------------
  // capture and send
  // ----------------------------------------------------------------------------
  // data latched on each rising clock edge: flag first, last bit on the 24th
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rxWord <= 24'h000000;
      rxCnt  <= 6'h00;
    end
    else if (csPrev_r && !csN)
      rxCnt <= 6'h00;                    // new frame
    else if (sckIn && !sckPrev_r)
    begin
      rxWord <= {rxWord[22:0], sdoPin};
      rxCnt  <= (rxCnt == 6'h18) ? 6'h01 : rxCnt + 6'h01;
    end
  end

  // input bits change on falling edges, far from the sampling rise
  always_ff @(posedge mclk)
  begin
    if (srst)
      sdi <= 1'h0;
    else if (csPrev_r && !csN)
      sdi <= cfgTx[7];
    else if (!sckIn && sckPrev_r)
      sdi <= (rxCnt < 6'h08) ? cfgTx[3'(6'h07 - rxCnt)] : ~sdi;
  end
endmodule : adcsp_host

// ---- tb/tb_adc_internal_sck_serial_port.sv ----
// tb_adc_internal_sck_serial_port: self-checking bench of the converter serial port
module tb_adc_internal_sck_serial_port;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // signals and table
  // ----------------------------------------------------------------------------
  typedef struct packed { logic [22:0] res; logic [7:0] cfg; logic [23:0] word; } adcsp_row_t;
  localparam int NROWS = 3;
  localparam int LIMIT = 30000;          // cycles; the whole run needs about 18000
  adcsp_row_t rows [NROWS] = '{'{23'h7fffff, 8'ha5, 24'h7fffff}, '{23'h000000, 8'h5a, 24'h000000},
                               '{23'h2aaaaa, 8'hc3, 24'h2aaaaa}};
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic        csN = 1'h1;
  logic        resValid = 1'h0;
  logic        extLow = 1'h0;
  logic [22:0] resData = 23'h000000;
  logic [7:0]  cfgTx = 8'h00;
  logic        sdi, sckIn, sckOut, sckOe, sckPullUpEn, sdoOut, sdoOe, sckAtFall;
  logic        resReady, convStart, sleepMode, intSckMode, cfgLoad;
  logic [7:0]  cfgWord;
  logic [23:0] rxWord;
  logic [5:0]  rxCnt;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          convCnt = 0;
  int          loadCnt = 0;
  int          cycles = 0;
  int          gap;
  int          n;

  always #4 mclk = ~mclk;

  // short conversion keeps the run brief
  adcsp_port #(.CONV_CYC(2000)) dut (
    .mclk(mclk), .srst(srst), .csN(csN), .sdi(sdi), .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe),
    .sckPullUpEn(sckPullUpEn), .sdoOut(sdoOut), .sdoOe(sdoOe), .resData(resData), .resValid(resValid),
    .resReady(resReady), .convStart(convStart), .sleepMode(sleepMode), .intSckMode(intSckMode),
    .cfgWord(cfgWord), .cfgLoad(cfgLoad));

  adcsp_host host (
    .mclk(mclk), .srst(srst), .csN(csN), .sckOut(sckOut), .sckOe(sckOe), .sckPullUpEn(sckPullUpEn),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .extLow(extLow), .cfgTx(cfgTx), .sckIn(sckIn), .sdi(sdi),
    .rxWord(rxWord), .rxCnt(rxCnt));

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // conversion starts counted; a hang is cut short here
  always @(posedge mclk)
  begin
    cycles++;
    if (convStart === 1'h1)
      convCnt++;
    if (cfgLoad === 1'h1)
      loadCnt++;
    if (cycles == LIMIT)
    begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc

  // waits for the done flag, times the first rise, then waits out 24 rises
  task automatic frame(output int g, output logic lvl);
    int k;
    for (k = 0; k < 6000 && !(sdoOe === 1'h1 && sdoOut === 1'h0); k++) cyc(1);
    lvl = sckOut;
    g = 0;
    while (rxCnt !== 6'h01 && g < 3000)
    begin
      cyc(1);
      g++;
    end
    for (k = 0; k < 700 && rxCnt !== 6'h18; k++) cyc(1);
    cyc(3);
  endtask : frame

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    cyc(4);
    srst <= 1'h0;
    chk("sdoOe in reset", 1'h0, sdoOe);
    chk("pull-up in reset", 1'h1, sckPullUpEn);
    $display("test reset done");
    cyc(1);
    // fill the result fifo until it refuses
    for (int i = 0; i < 8; i++)
    begin
      resData <= (i < NROWS) ? rows[i].res : 23'(i * 3);
      resValid <= 1'h1;
      cyc(1);
    end
    resValid <= 1'h0;
    cyc(2);
    chk("fifo full", 1'h0, resReady);
    chk("internal after reset", 1'h1, intSckMode);
    $display("test fifo done");
    // ordinary transfers, select lowered while converting
    for (int i = 0; i < NROWS; i++)
    begin
      cfgTx <= rows[i].cfg;
      chk("pull-up at select fall", 1'h1, sckPullUpEn);
      csN <= 1'h0;
      cyc(8);
      chk("busy flag", 2'h3, {sdoOe, sdoOut});
      chk("clock low", 2'h2, {sckOe, sckOut});
      n = convCnt;
      frame(gap, sckAtFall);
      chk("status delay", 1'h1, gap >= 1500 && gap <= 1530);
      chk("word", rows[i].word, rxWord);
      chk("config", rows[i].cfg, cfgWord);
      chk("after last rise", 3'h7, {sdoOut, sckOut, convCnt == n + 1});
      csN <= 1'h1;
      cyc(6);
      chk("released", 1'h0, sdoOe);
      $display("test row %0d done", i);
    end
    // short status test that finds the result ready
    for (int k = 0; k < 3000 && sleepMode !== 1'h1; k++) cyc(1);
    chk("sleep with select high", 1'h1, sleepMode);
    n = convCnt;
    csN <= 1'h0;
    cyc(10);
    chk("done flag", 3'h4, {sdoOe, sdoOut, sckOut});
    chk("awake in test", 1'h0, sleepMode);
    csN <= 1'h1;
    cyc(8);
    chk("pull-up back", 1'h1, sckPullUpEn);
    chk("back asleep", 3'h4, {sleepMode, sdoOe, convCnt != n});
    $display("test status done");
    // abort after four rises, clock high at that moment
    cfgTx <= 8'h3c;
    n = convCnt;
    csN <= 1'h0;
    for (int k = 0; k < 2500 && rxCnt !== 6'h04; k++) cyc(1);
    csN <= 1'h1;
    cyc(8);
    chk("old config kept", rows[NROWS-1].cfg, cfgWord);
    chk("abort converts", 1'h1, convCnt == n + 1);
    chk("config loads", 32'h3, loadCnt);
    $display("test abort done");
    // clock pin held low by an outside driver
    extLow <= 1'h1;
    cyc(5);
    chk("pull-up off", 1'h0, sckPullUpEn);
    csN <= 1'h0;
    cyc(8);
    chk("external mode", 3'h1, {intSckMode, sckOe, sdoOe});
    extLow <= 1'h0;
    cyc(5);
    chk("pin stays low", 1'h0, sckIn);
    csN <= 1'h1;
    cyc(4);
    $display("test external done");
    // continuous mode: select held low through reset
    srst <= 1'h1;
    csN <= 1'h0;
    cyc(4);
    srst <= 1'h0;
    cyc(8);
    chk("continuous mode", 1'h1, intSckMode);
    resData <= 23'h55aa33;
    resValid <= 1'h1;
    cyc(1);
    resValid <= 1'h0;
    cyc(100);
    chk("converting levels", 2'h3, {sckOut, sdoOut});
    frame(gap, sckAtFall);
    chk("done levels", 1'h0, sckAtFall);
    chk("sleep before clock", 1'h1, gap >= 10 && gap <= 30);
    chk("continuous word", 24'h55aa33, rxWord);
    chk("continuous config", 8'h3c, cfgWord);
    chk("converting again", 2'h3, {sckOut, sdoOut});
    $display("test continuous done");
    complete_run();
  end
endmodule : tb_adc_internal_sck_serial_port
